// >>> verilog/synth_cal_consts.svh
// register offsets, field positions, reset values and wake constants
// of the synthesizer calibration, test and identification register slice.
// assumes the serial port front end hands over a decoded header byte.
`ifndef SYNTH_CAL_CONSTS_SVH
`define SYNTH_CAL_CONSTS_SVH

// ****************************************************************
// register offsets (low six bits of the header byte)
// ****************************************************************
`define ADR_CHARGEPUMP_CAL 6'h23
`define ADR_VCO_CURRENT_CAL 6'h24
`define ADR_COARSE_TUNE_CAL 6'h25
`define ADR_CAL_CONTROL 6'h26
`define ADR_RESERVED_A 6'h29
`define ADR_RESERVED_B 6'h2A
`define ADR_RESERVED_C 6'h2B
`define ADR_ANALOG_TEST_A 6'h2C
`define ADR_ANALOG_TEST_B 6'h2D
`define ADR_ANALOG_TEST_C 6'h2E
`define ADR_PART_ID 6'h30
`define ADR_REVISION 6'h31

// ****************************************************************
// writable bit masks
// ****************************************************************
`define MSK_CHARGEPUMP_CAL 8'hFF
`define MSK_VCO_CURRENT_CAL 8'h3F
`define MSK_COARSE_TUNE_CAL 8'h3F
`define MSK_CAL_CONTROL 8'h7F
`define MSK_FULL 8'hFF

// ****************************************************************
// field positions
// ****************************************************************
`define FLD_CP_CFG_HI 7
`define FLD_CP_CFG_LO 6
`define FLD_CP_EN_HI 5
`define FLD_CP_EN_LO 4
`define FLD_CP_CUR_HI 3
`define FLD_VCO_CORE 5
`define FLD_VCO_CUR_HI 4
`define FLD_COARSE_HI 5
`define FLD_CTRL_HI 6
`define FLD_VCO_SEL_EN 1

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CHARGEPUMP_CAL 8'hA9
`define RST_VCO_CURRENT_CAL 8'h0A
`define RST_COARSE_TUNE_CAL 8'h20
`define RST_CAL_CONTROL 8'h0D
`define RST_RESERVED_A 8'h59
`define RST_RESERVED_B 8'h7F
`define RST_RESERVED_C 8'h3F
`define RST_ANALOG_TEST_A 8'h88
`define RST_ANALOG_TEST_B 8'h31
`define RST_ANALOG_TEST_C 8'h0B

// ****************************************************************
// wake inversion: 0x88 ^ 0x81 and 0x31 ^ 0x35
// ****************************************************************
`define INV_ANALOG_TEST_A 8'h09
`define INV_ANALOG_TEST_B 8'h04

`endif

// >>> verilog/synth_cal_pkg.sv
// types shared by the calibration register slice and its read back.
// assumes the constants header is compiled alongside.
package synth_cal_pkg;

    // ****************************************************************
    // stored register contents
    // ****************************************************************
    typedef struct packed {
        logic [7:0] chargepump_cal;
        logic [7:0] vco_current_cal;
        logic [7:0] coarse_tune_cal;
        logic [7:0] cal_control;
        logic [7:0] reserved_a;
        logic [7:0] reserved_b;
        logic [7:0] reserved_c;
        logic [7:0] analog_test_a;
        logic [7:0] analog_test_b;
        logic [7:0] analog_test_c;
    } reg_file_s;

    // ****************************************************************
    // settings handed to the synthesizer and analog section
    // ****************************************************************
    typedef struct packed {
        logic [1:0] chargepump_cfg;
        logic [1:0] chargepump_cal_enable;
        logic cp_stage_skip;
        logic [3:0] chargepump_current;
        logic vco_core_select;
        logic [4:0] vco_current;
        logic [5:0] coarse_tune;
        logic [6:0] cal_control;
        logic vco_select_cal_enable;
        logic [7:0] reserved_a;
        logic [7:0] reserved_b;
        logic [7:0] reserved_c;
        logic [7:0] analog_test_a;
        logic [7:0] analog_test_b;
        logic [7:0] analog_test_c;
    } synth_ctrl_s;

    // ****************************************************************
    // results from the calibration engine
    // ****************************************************************
    typedef struct packed {
        logic cp_we;
        logic [3:0] cp_current;
        logic vco_we;
        logic [4:0] vco_current;
        logic coarse_we;
        logic [5:0] coarse_tune;
    } cal_result_s;

endpackage

// >>> verilog/synth_cal_readback.sv
// registered read multiplexer of the calibration register slice.
// assumes the read strobe and address are on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "synth_cal_consts.svh"

module synth_cal_readback #(
    parameter logic [7:0] PART_ID = 8'hA5,
    parameter logic [7:0] REVISION = 8'h3C
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_rd,
    input wire logic [5:0] i_addr,
    input wire synth_cal_pkg::reg_file_s i_regs,
    output logic [7:0] o_rdata,
    output logic o_rvalid
);

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } rb_state_s;

    rb_state_s st_r;
    rb_state_s st_nxt;

    // ****************************************************************
    // address decode
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = i_rd;
        if (i_rd) begin
            case (i_addr)
                `ADR_CHARGEPUMP_CAL: st_nxt.rdata = i_regs.chargepump_cal;
                `ADR_VCO_CURRENT_CAL: st_nxt.rdata = i_regs.vco_current_cal;
                `ADR_COARSE_TUNE_CAL: st_nxt.rdata = i_regs.coarse_tune_cal;
                `ADR_CAL_CONTROL: st_nxt.rdata = i_regs.cal_control;
                `ADR_RESERVED_A: st_nxt.rdata = i_regs.reserved_a;
                `ADR_RESERVED_B: st_nxt.rdata = i_regs.reserved_b;
                `ADR_RESERVED_C: st_nxt.rdata = i_regs.reserved_c;
                `ADR_ANALOG_TEST_A: st_nxt.rdata = i_regs.analog_test_a;
                `ADR_ANALOG_TEST_B: st_nxt.rdata = i_regs.analog_test_b;
                `ADR_ANALOG_TEST_C: st_nxt.rdata = i_regs.analog_test_c;
                `ADR_PART_ID: st_nxt.rdata = PART_ID;
                `ADR_REVISION: st_nxt.rdata = REVISION;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_rvalid = st_r.rvalid;

endmodule
`default_nettype wire

// >>> verilog/synth_cal_regs.sv
// synthesizer calibration, sleep-volatile test and identification registers.
// assumes the serial port front end and the calibration engine run on
// i_sys_clk and that the sleep level comes from the radio control logic.
`timescale 1ns/1ps
`default_nettype none
`include "synth_cal_consts.svh"

module synth_cal_regs #(
    parameter int ADDR_W = 8,
    parameter logic [7:0] PART_ID = 8'hA5,
    parameter logic [7:0] REVISION = 8'h3C
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire synth_cal_pkg::cal_result_s i_cal,
    input wire logic i_sleep,
    input wire logic i_select_a,
    output synth_cal_pkg::synth_ctrl_s o_ctrl,
    output logic o_awake
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the header byte carries at least the six offset bits
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr_w
        $error("ADDR_W must lie between 6 and 8");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [2:0] {
        PWR_AWAKE = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_WAKE = 3'b100
    } pwr_e;

    typedef struct packed {
        synth_cal_pkg::reg_file_s regs;
        pwr_e pwr;
        logic inv_test_a;
        logic inv_test_b;
        synth_cal_pkg::synth_ctrl_s ctrl;
        logic awake;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic [5:0] offset;
    logic host_wr;

    assign offset = i_reg_addr[5:0];

    // ****************************************************************
    // helpers
    // ****************************************************************
    // only the writable bits take the new value; the rest stay zero
    function automatic logic [7:0] merge_wr(input logic [7:0] data,
                                            input logic [7:0] mask);
        merge_wr = data & mask;
    endfunction

    function automatic synth_cal_pkg::reg_file_s volatile_defaults(
            input synth_cal_pkg::reg_file_s regs);
        synth_cal_pkg::reg_file_s r;
        r = regs;
        r.reserved_a = `RST_RESERVED_A;
        r.reserved_b = `RST_RESERVED_B;
        r.reserved_c = `RST_RESERVED_C;
        r.analog_test_a = `RST_ANALOG_TEST_A;
        r.analog_test_b = `RST_ANALOG_TEST_B;
        r.analog_test_c = `RST_ANALOG_TEST_C;
        volatile_defaults = r;
    endfunction

    function automatic synth_cal_pkg::reg_file_s reset_regs();
        synth_cal_pkg::reg_file_s r;
        r.chargepump_cal = `RST_CHARGEPUMP_CAL;
        r.vco_current_cal = `RST_VCO_CURRENT_CAL;
        r.coarse_tune_cal = `RST_COARSE_TUNE_CAL;
        r.cal_control = `RST_CAL_CONTROL;
        r.reserved_a = `RST_RESERVED_A;
        r.reserved_b = `RST_RESERVED_B;
        r.reserved_c = `RST_RESERVED_C;
        r.analog_test_a = `RST_ANALOG_TEST_A;
        r.analog_test_b = `RST_ANALOG_TEST_B;
        r.analog_test_c = `RST_ANALOG_TEST_C;
        reset_regs = r;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    // writes are refused while asleep or waking; reads are still served then
    assign host_wr = i_reg_wr && (st_r.pwr == PWR_AWAKE);

    always_comb begin
        st_nxt = st_r;

        // sleep sequencing
        case (st_r.pwr)
            PWR_AWAKE: begin
                if (i_sleep) begin
                    st_nxt.pwr = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                st_nxt.regs = volatile_defaults(st_r.regs);
                st_nxt.inv_test_a = 1'b0;
                st_nxt.inv_test_b = 1'b0;
                if (!i_sleep) begin
                    st_nxt.pwr = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                // stored value stays at reset; inversion lives in a flag
                st_nxt.inv_test_a = i_select_a;
                st_nxt.inv_test_b = i_select_a;
                st_nxt.pwr = PWR_AWAKE;
            end
            default: begin
                st_nxt.pwr = PWR_AWAKE;
            end
        endcase

        // host writes
        if (host_wr) begin
            case (offset)
                `ADR_CHARGEPUMP_CAL: begin
                    st_nxt.regs.chargepump_cal =
                        merge_wr(i_reg_wdata, `MSK_CHARGEPUMP_CAL);
                end
                `ADR_VCO_CURRENT_CAL: begin
                    st_nxt.regs.vco_current_cal =
                        merge_wr(i_reg_wdata, `MSK_VCO_CURRENT_CAL);
                end
                `ADR_COARSE_TUNE_CAL: begin
                    st_nxt.regs.coarse_tune_cal =
                        merge_wr(i_reg_wdata, `MSK_COARSE_TUNE_CAL);
                end
                `ADR_CAL_CONTROL: begin
                    st_nxt.regs.cal_control =
                        merge_wr(i_reg_wdata, `MSK_CAL_CONTROL);
                end
                `ADR_RESERVED_A: begin
                    st_nxt.regs.reserved_a = merge_wr(i_reg_wdata, `MSK_FULL);
                end
                `ADR_RESERVED_B: begin
                    st_nxt.regs.reserved_b = merge_wr(i_reg_wdata, `MSK_FULL);
                end
                `ADR_RESERVED_C: begin
                    st_nxt.regs.reserved_c = merge_wr(i_reg_wdata, `MSK_FULL);
                end
                `ADR_ANALOG_TEST_A: begin
                    // a host write replaces the wake value and its inversion
                    st_nxt.regs.analog_test_a = merge_wr(i_reg_wdata, `MSK_FULL);
                    st_nxt.inv_test_a = 1'b0;
                end
                `ADR_ANALOG_TEST_B: begin
                    st_nxt.regs.analog_test_b = merge_wr(i_reg_wdata, `MSK_FULL);
                    st_nxt.inv_test_b = 1'b0;
                end
                `ADR_ANALOG_TEST_C: begin
                    st_nxt.regs.analog_test_c = merge_wr(i_reg_wdata, `MSK_FULL);
                end
                default: begin
                    // identification and unmapped offsets ignore writes
                    st_nxt.regs = st_nxt.regs;
                end
            endcase
        end

        // calibration results win over a host write in the same cycle
        if (i_cal.cp_we) begin
            st_nxt.regs.chargepump_cal[`FLD_CP_CUR_HI:0] = i_cal.cp_current;
        end
        if (i_cal.vco_we) begin
            st_nxt.regs.vco_current_cal[`FLD_VCO_CUR_HI:0] = i_cal.vco_current;
        end
        if (i_cal.coarse_we) begin
            st_nxt.regs.coarse_tune_cal[`FLD_COARSE_HI:0] = i_cal.coarse_tune;
        end

        // settings for the synthesizer, one cycle behind the registers
        st_nxt.ctrl.chargepump_cfg =
            st_r.regs.chargepump_cal[`FLD_CP_CFG_HI:`FLD_CP_CFG_LO];
        st_nxt.ctrl.chargepump_cal_enable =
            st_r.regs.chargepump_cal[`FLD_CP_EN_HI:`FLD_CP_EN_LO];
        st_nxt.ctrl.cp_stage_skip =
            (st_r.regs.chargepump_cal[`FLD_CP_EN_HI:`FLD_CP_EN_LO] == 2'b00);
        // current follows 2^(value/4); the exponent is handed on as is
        st_nxt.ctrl.chargepump_current =
            st_r.regs.chargepump_cal[`FLD_CP_CUR_HI:0];
        st_nxt.ctrl.vco_core_select =
            st_r.regs.vco_current_cal[`FLD_VCO_CORE];
        st_nxt.ctrl.vco_current =
            st_r.regs.vco_current_cal[`FLD_VCO_CUR_HI:0];
        st_nxt.ctrl.coarse_tune =
            st_r.regs.coarse_tune_cal[`FLD_COARSE_HI:0];
        st_nxt.ctrl.cal_control = st_r.regs.cal_control[`FLD_CTRL_HI:0];
        st_nxt.ctrl.vco_select_cal_enable =
            st_r.regs.analog_test_c[`FLD_VCO_SEL_EN];
        st_nxt.ctrl.reserved_a = st_r.regs.reserved_a;
        st_nxt.ctrl.reserved_b = st_r.regs.reserved_b;
        st_nxt.ctrl.reserved_c = st_r.regs.reserved_c;
        // inversion reaches only the analog side, never the read path
        st_nxt.ctrl.analog_test_a = st_r.regs.analog_test_a ^
            (st_r.inv_test_a ? `INV_ANALOG_TEST_A : 8'h00);
        st_nxt.ctrl.analog_test_b = st_r.regs.analog_test_b ^
            (st_r.inv_test_b ? `INV_ANALOG_TEST_B : 8'h00);
        st_nxt.ctrl.analog_test_c = st_r.regs.analog_test_c;
        st_nxt.awake = (st_nxt.pwr == PWR_AWAKE);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r.regs <= reset_regs();
            st_r.pwr <= PWR_AWAKE;
            st_r.inv_test_a <= 1'b0;
            st_r.inv_test_b <= 1'b0;
            st_r.ctrl.chargepump_cfg <= 2'h2;
            st_r.ctrl.chargepump_cal_enable <= 2'h2;
            st_r.ctrl.cp_stage_skip <= 1'b0;
            st_r.ctrl.chargepump_current <= 4'h9;
            st_r.ctrl.vco_core_select <= 1'b0;
            st_r.ctrl.vco_current <= 5'h0A;
            st_r.ctrl.coarse_tune <= 6'h20;
            st_r.ctrl.cal_control <= 7'h0D;
            st_r.ctrl.vco_select_cal_enable <= 1'b1;
            st_r.ctrl.reserved_a <= `RST_RESERVED_A;
            st_r.ctrl.reserved_b <= `RST_RESERVED_B;
            st_r.ctrl.reserved_c <= `RST_RESERVED_C;
            st_r.ctrl.analog_test_a <= `RST_ANALOG_TEST_A;
            st_r.ctrl.analog_test_b <= `RST_ANALOG_TEST_B;
            st_r.ctrl.analog_test_c <= `RST_ANALOG_TEST_C;
            st_r.awake <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // read back
    // ****************************************************************
    // both top bits of the header are ignored, so 0x30 and 0xF0 meet
    synth_cal_readback #(
        .PART_ID(PART_ID),
        .REVISION(REVISION)
    ) u_readback (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_rd(i_reg_rd),
        .i_addr(offset),
        .i_regs(st_r.regs),
        .o_rdata(o_reg_rdata),
        .o_rvalid(o_reg_rvalid)
    );

    assign o_ctrl = st_r.ctrl;
    assign o_awake = st_r.awake;

endmodule
`default_nettype wire

// >>> test/synth_cal_regs_props.sv
// checker for the calibration, test and identification register slice.
// assumes it is bound into synth_cal_regs and sees one clock domain.
`timescale 1ns/1ps
`default_nettype none
module synth_cal_regs_props #(
    parameter int ADDR_W = 8,
    parameter logic [7:0] PART_ID = 8'hA5,
    parameter logic [7:0] REVISION = 8'h3C
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire synth_cal_pkg::cal_result_s i_cal,
    input wire logic i_sleep,
    input wire logic i_select_a,
    input wire synth_cal_pkg::synth_ctrl_s o_ctrl,
    input wire logic o_awake
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // ****************************************************************
    // read port
    // ****************************************************************
    sequence s_rd(a);
        i_reg_rd && i_reg_addr[5:0] == a;
    endsequence
    property p_part_id;
        s_rd(6'h30) |=> o_reg_rvalid && o_reg_rdata == PART_ID;
    endproperty
    a_part_id: assert property (p_part_id) else $error("part id read wrong");
    property p_revision;
        s_rd(6'h31) |=> o_reg_rdata == REVISION;
    endproperty
    a_revision: assert property (p_revision) else $error("revision read wrong");
    property p_unmapped;
        s_rd(6'h27) |=> o_reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_unused_bits;
        s_rd(6'h24) |=> o_reg_rdata[7:6] == 2'b00;
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused bits set");
    // inversion must never leak to the read path
    property p_test_a_read;
        s_rd(6'h2C) and o_ctrl.analog_test_a == 8'h81 |=> o_reg_rdata == 8'h88;
    endproperty
    a_test_a_read: assert property (p_test_a_read) else $error("test a read shows inversion");
    property p_test_b_read;
        s_rd(6'h2D) and o_ctrl.analog_test_b == 8'h35 |=> o_reg_rdata == 8'h31;
    endproperty
    a_test_b_read: assert property (p_test_b_read) else $error("test b read shows inversion");
    // ****************************************************************
    // settings to the synthesizer
    // ****************************************************************
    // skip must follow the enable field of a taken write, two edges later
    sequence s_cp_wr;
        i_reg_wr && o_awake && i_reg_addr[5:0] == 6'h23;
    endsequence
    property p_skip;
        s_cp_wr |=> ##1 o_ctrl.cp_stage_skip == ($past(i_reg_wdata[5:4], 2) == 2'b00);
    endproperty
    a_skip: assert property (p_skip) else $error("charge pump skip mismatch");
    property p_sel_cal;
        o_ctrl.vco_select_cal_enable == o_ctrl.analog_test_c[1];
    endproperty
    a_sel_cal: assert property (p_sel_cal) else $error("vco select enable mismatch");
    sequence s_core_wr;
        i_reg_wr && o_awake && !i_sleep && !$past(i_sleep) && i_reg_addr[5:0] == 6'h24;
    endsequence
    property p_core_sel;
        s_core_wr |=> ##1 o_ctrl.vco_core_select == $past(i_reg_wdata[5], 2);
    endproperty
    a_core_sel: assert property (p_core_sel) else $error("vco core select wrong");
    property p_cal_cp;
        i_cal.cp_we |=> ##1 o_ctrl.chargepump_current == $past(i_cal.cp_current, 2);
    endproperty
    a_cal_cp: assert property (p_cal_cp) else $error("charge pump result lost");
    property p_cal_vco;
        i_cal.vco_we |=> ##1 o_ctrl.vco_current == $past(i_cal.vco_current, 2);
    endproperty
    a_cal_vco: assert property (p_cal_vco) else $error("vco current result lost");
    property p_cal_coarse;
        i_cal.coarse_we |=> ##1 o_ctrl.coarse_tune == $past(i_cal.coarse_tune, 2);
    endproperty
    a_cal_coarse: assert property (p_cal_coarse) else $error("coarse result lost");
endmodule
bind synth_cal_regs synth_cal_regs_props #(
    .ADDR_W(ADDR_W), .PART_ID(PART_ID), .REVISION(REVISION)
) i_props (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_cal(i_cal), .i_sleep(i_sleep),
    .i_select_a(i_select_a), .o_ctrl(o_ctrl), .o_awake(o_awake)
);
`default_nettype wire

// >>> test/host_model.sv
// host side of the serial register port, one byte per strobe.
// assumes the slice samples strobes on the rising edge of i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int ADDR_W = 8
) (
    input wire logic i_sys_clk,
    output logic o_wr,
    output logic o_rd,
    output logic [ADDR_W-1:0] o_addr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = '0;
        o_wdata = 8'h00;
    end
    // any offset may be written, read-only ones included
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        #1 o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_sys_clk);
        #1 o_wr = 1'b0;
        // released data flips so a stale byte never looks valid
        o_wdata = ~d;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic ok);
        @(posedge i_sys_clk);
        #1 o_rd = 1'b1;
        o_addr = a;
        @(posedge i_sys_clk);
        #1 o_rd = 1'b0;
        ok = (i_rvalid === 1'b1);
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the calibration register slice.
// assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] PART_ID = 8'h5A; // arbitrary
    localparam logic [7:0] REVISION = 8'hC3; // arbitrary
    localparam logic [7:0] ADR [10] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h29,
        8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
    localparam logic [7:0] RST [10] = '{8'hA9, 8'h0A, 8'h20, 8'h0D, 8'h59,
        8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B};
    localparam logic [7:0] MSK [10] = '{8'hFF, 8'h3F, 8'h3F, 8'h7F, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sleep = 1'b0;
    logic select_a = 1'b0;
    synth_cal_pkg::cal_result_s cal = '0;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic awake;
    synth_cal_pkg::synth_ctrl_s ctrl;
    int errors = 0;
    int compares = 0;
    always #2.5 sys_clk = ~sys_clk;
    host_model #(.ADDR_W(8)) i_host (.i_sys_clk(sys_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
    synth_cal_regs #(.ADDR_W(8), .PART_ID(PART_ID), .REVISION(REVISION)) i_dut (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_cal(cal), .i_sleep(sleep), .i_select_a(select_a), .o_ctrl(ctrl), .o_awake(awake));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic final_report();
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_host.rd_reg(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        for (int k = 0; k < 10; k++) begin
            rd_chk(ADR[k], RST[k]);
        end
        chk(ctrl.cp_stage_skip, 1'b0);
        chk(ctrl.chargepump_current, 4'h9);
        chk(ctrl.vco_current, 5'h0A);
        chk(ctrl.coarse_tune, 6'h20);
        chk(ctrl.vco_select_cal_enable, 1'b1);
    endtask
    task automatic t_rw();
        for (int k = 0; k < 10; k++) begin
            i_host.wr_reg(ADR[k], 8'hFF);
            rd_chk(ADR[k], MSK[k]);
        end
        i_host.wr_reg(8'h23, 8'h80);
        i_host.wr_reg(8'h24, 8'h25);
        i_host.wr_reg(8'h2E, 8'h00);
        cyc(2);
        chk(ctrl.cp_stage_skip, 1'b1);
        chk(ctrl.vco_core_select, 1'b1);
        chk(ctrl.vco_current, 5'h05);
        chk(ctrl.vco_select_cal_enable, 1'b0);
        i_host.wr_reg(8'h30, 8'h00);
        i_host.wr_reg(8'h31, 8'h00);
        rd_chk(8'h30, PART_ID);
        rd_chk(8'hF0, PART_ID);
        rd_chk(8'h31, REVISION);
        rd_chk(8'h27, 8'h00);
    endtask
    task automatic t_cal();
        @(posedge sys_clk);
        #1 cal = {1'b1, 4'h3, 1'b1, 5'h11, 1'b1, 6'h2A};
        @(posedge sys_clk);
        #1 cal = '0;
        rd_chk(8'h23, 8'h83);
        rd_chk(8'h24, 8'h31);
        rd_chk(8'h25, 8'h2A);
        chk(ctrl.chargepump_current, 4'h3);
    endtask
    task automatic t_sleep(input logic sel);
        i_host.wr_reg(8'h29, 8'h00);
        i_host.wr_reg(8'h2C, 8'h00);
        i_host.wr_reg(8'h2D, 8'h00);
        select_a = sel;
        sleep = 1'b1;
        cyc(4);
        chk(awake, 1'b0);
        // refused while asleep, so 0x24 keeps its value
        i_host.wr_reg(8'h24, 8'h00);
        sleep = 1'b0;
        cyc(6);
        chk(awake, 1'b1);
        chk(ctrl.analog_test_a, sel ? 8'h81 : 8'h88);
        chk(ctrl.analog_test_b, sel ? 8'h35 : 8'h31);
        rd_chk(8'h2C, 8'h88);
        rd_chk(8'h2D, 8'h31);
        rd_chk(8'h29, 8'h59);
        rd_chk(8'h2E, 8'h0B);
        rd_chk(8'h24, 8'h31);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        t_reset();
        t_rw();
        t_cal();
        t_sleep(1'b1);
        t_sleep(1'b0);
        final_report();
    end
    // whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
